// [core/pcg_consts.svh]
// Offsets, field positions, gate mask and reset values of the gate bank.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
`define PCG_OFF_RUN 12'h100
`define PCG_OFF_SLEEP 12'h110
`define PCG_OFF_DEEP 12'h120
`define PCG_OFF_MODE 12'h130
`define PCG_BIT_CAN 24
`define PCG_BIT_LPK 6
`define PCG_BIT_WDG 3
`define PCG_BIT_ACG 0
`define PCG_GATE_MASK 32'h0100_0048
`define PCG_GATE_RESET 32'h0000_0040
`define PCG_DEEP_RESET 32'h0000_0040
`define PCG_MODE_RESET 32'h0000_0000
`endif

// [core/pcg_pkg.sv]
// Types shared by the clock gate bank.
`default_nettype none
package pcg_pkg;
  typedef enum logic [2:0] {
    PCG_RUN = 3'h1,
    PCG_SLEEP = 3'h2,
    PCG_DEEP = 3'h4
  } pcg_pmode_t;
  typedef struct packed {
    logic [2:0] run;
    logic [2:0] slp;
    logic [2:0] deep;
    logic auto_clock_gating_select;
    logic [31:0] rdata;
  } pcg_regs_t;
endpackage
`default_nettype wire

// [core/pcg_gate_cell.sv]
// Glitch-free clock gate cell with fault flag for one peripheral.
`default_nettype none
module pcg_gate_cell (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic enable_in,
  input wire logic access_in,
  // Results
  output logic gclk_out,
  output logic clk_en_out,
  output logic fault_out
);
  typedef struct packed {
    logic en;
    logic flt;
  } pcg_cell_t;
  pcg_cell_t st_ff;
  pcg_cell_t nxt_st;
  logic latch_en;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.en = enable_in;
    nxt_st.flt = access_in & ~st_ff.en;
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // The latch is open only while the clock is low, so the gate never clips a high phase.
  always_latch begin
    if (!ref_clk_in) begin
      latch_en = st_ff.en;
    end
  end
  assign gclk_out = ref_clk_in & latch_en;
  assign clk_en_out = st_ff.en;
  assign fault_out = st_ff.flt;
endmodule
`default_nettype wire

// [core/pcg_bank.sv]
// Peripheral clock gate bank zero: run, sleep and deep-sleep gate registers.
//
// Functional notes
// [R01] Each writable bit enables one unit's clock.
// [R02] Access to a gated unit raises bus fault.
// [R03] Gate bits reset cleared unless noted. The deep-sleep register resets to 0x00000040 here.
// [R04] Run at 0x100, sleep at 0x110.
// [R05] Sleep registers apply only with auto gating.
// [R06] Bit 24 gates the CAN unit.
// [R07] Bit 6 gates the low power keeper.
// [R08] Bit 3 gates the watchdog.
// [R09] Reserved bits read zero, ignore writes.
// [R10] Run and sleep reset to 0x00000040.
// [R11] Deep-sleep register at 0x120, same layout.
// [R12] Without auto gating, run register always governs.
//
// Decided for this implementation: the plain strobed port.
`include "pcg_consts.svh"
`default_nettype none
module pcg_bank (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Power mode of the system
  input wire pcg_pkg::pcg_pmode_t pmode_in,
  // Peripheral accesses, one bit per unit: 0 watchdog, 1 keeper, 2 CAN
  input wire logic [2:0] periph_access_in,
  // Gated clocks, enables and faults
  output logic [2:0] gclk_out,
  output logic [2:0] clk_en_out,
  output logic [2:0] bus_fault_out
);
  import pcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  pcg_regs_t st_ff;
  pcg_regs_t nxt_st;
  logic [2:0] eff_en;

  function automatic logic [2:0] pcg_pick(input logic [31:0] d);
    pcg_pick = {d[`PCG_BIT_CAN], d[`PCG_BIT_LPK], d[`PCG_BIT_WDG]}; // [R06] [R07] [R08]
  endfunction

  function automatic logic [31:0] pcg_spread(input logic [2:0] g);
    pcg_spread = '0; // [R09]
    pcg_spread[`PCG_BIT_CAN] = g[2];
    pcg_spread[`PCG_BIT_LPK] = g[1];
    pcg_spread[`PCG_BIT_WDG] = g[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = '0;
    if (wr_in) begin
      case (addr_in)
        `PCG_OFF_RUN: nxt_st.run = pcg_pick(wdata_in); // [R04] [R01]
        `PCG_OFF_SLEEP: nxt_st.slp = pcg_pick(wdata_in); // [R04]
        `PCG_OFF_DEEP: nxt_st.deep = pcg_pick(wdata_in); // [R11]
        `PCG_OFF_MODE: nxt_st.auto_clock_gating_select = wdata_in[`PCG_BIT_ACG];
        default: nxt_st.auto_clock_gating_select = st_ff.auto_clock_gating_select;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        `PCG_OFF_RUN: nxt_st.rdata = pcg_spread(st_ff.run);
        `PCG_OFF_SLEEP: nxt_st.rdata = pcg_spread(st_ff.slp);
        `PCG_OFF_DEEP: nxt_st.rdata = pcg_spread(st_ff.deep);
        `PCG_OFF_MODE: nxt_st.rdata = {31'h0000_0000, st_ff.auto_clock_gating_select};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Mode registers only take over when auto gating is on.
  always_comb begin
    eff_en = st_ff.run; // [R12]
    if (st_ff.auto_clock_gating_select) begin // [R05]
      case (pmode_in)
        PCG_RUN: eff_en = st_ff.run;
        PCG_SLEEP: eff_en = st_ff.slp;
        PCG_DEEP: eff_en = st_ff.deep;
        default: eff_en = st_ff.run;
      endcase
    end
  end

  // Reset follows the register-level value, which sets the keeper bit.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff.run <= pcg_pick(`PCG_GATE_RESET); // [R10] [R03]
      st_ff.slp <= pcg_pick(`PCG_GATE_RESET); // [R10]
      st_ff.deep <= pcg_pick(`PCG_DEEP_RESET);
      st_ff.auto_clock_gating_select <= 1'b0;
      st_ff.rdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // One gate per unit; enables and faults are registered inside the cell.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cell
      pcg_gate_cell u_cell (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .enable_in(eff_en[gi]), // [R01] [R12]
        .access_in(periph_access_in[gi]), // [R02]
        .gclk_out(gclk_out[gi]),
        .clk_en_out(clk_en_out[gi]),
        .fault_out(bus_fault_out[gi])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// [verification/pcg_bank_monitor.sv]
// Port checker of the gate bank.
`default_nettype none
module pcg_bank_monitor (
  // Clock
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Bus
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // Units
  input wire pcg_pkg::pcg_pmode_t pmode_in,
  input wire logic [2:0] periph_access_in,
  input wire logic [2:0] clk_en_out,
  input wire logic [2:0] bus_fault_out
);
  import pcg_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_fault_src: assert property (bus_fault_out == $past(periph_access_in & ~clk_en_out))
    else $error("fault");
  chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 0)
    else $error("idle");
  chk_rsvd_zero: assert property ($past(rd_in) && $past(addr_in) != 12'h130 |->
    (rdata_out & ~32'h0100_0048) == 0) else $error("rsvd");
  chk_mode_rsvd: assert property ($past(rd_in) && $past(addr_in) == 12'h130 |->
    rdata_out[31:1] == 0) else $error("mode");
  chk_reset_keeper: assert property ($rose(nrst_in) |-> ##1 clk_en_out == 3'h2)
    else $error("reset");
  chk_run_write: assert property (
    wr_in && addr_in == 12'h100 && pmode_in == PCG_RUN ##1 !wr_in && pmode_in == PCG_RUN
    |-> ##1 clk_en_out == $past({wdata_in[24], wdata_in[6], wdata_in[3]}, 2)) else $error("en");
  chk_rd_back: assert property (
    wr_in && addr_in == 12'h100 ##1 !wr_in ##1 rd_in && addr_in == 12'h100
    |-> ##1 rdata_out == ($past(wdata_in, 3) & 32'h0100_0048)) else $error("back");
  // The enables settle on the first edge out of reset, so the hold window starts after it.
  chk_en_hold: assert property (nrst_in && !wr_in ##1 $stable(pmode_in) |->
    ##1 $stable(clk_en_out)) else $error("hold");
  cov_fault: cover property (bus_fault_out != 0);
  cov_sleep: cover property (pmode_in == PCG_SLEEP && clk_en_out == 3'h5);
  cov_deep: cover property (pmode_in == PCG_DEEP);
endmodule
bind pcg_bank pcg_bank_monitor mon (.*);
`default_nettype wire

// [verification/pcg_bank_test.sv]
// Bench of the gate bank.
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module pcg_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pcg_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0;
  logic [11:0] ad = 0;
  logic [31:0] wd = 0, q, r;
  logic [2:0] acc = 0, a, en, flt, g;
  pcg_pmode_t pm = PCG_RUN;
  int bad_count = 0, num_checks = 0;
  always #2 clk = ~clk;
  pcg_bank DUT (.ref_clk_in(clk), .nrst_in(nrst), .addr_in(ad), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(q), .pmode_in(pm), .periph_access_in(acc), .gclk_out(g),
    .clk_en_out(en), .bus_fault_out(flt));
  task automatic bus(input logic w, input logic [11:0] x, input logic [31:0] d);
    @(posedge clk);
    ad <= x;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    r = $urandom(38);
    repeat (10) @(posedge clk);
    nrst <= 1;
    bus(0, 12'h110, 0);
    `CHK(q, 32'h40)
    bus(0, 12'h104, 0);
    `CHK(q, 0)
    `CHK(en, 3'h2)
    repeat (8) begin
      r = $urandom();
      bus(1, 12'h100, r);
      bus(0, 12'h100, 0);
      `CHK(q, r & 32'h0100_0048)
      `CHK(en, {r[24], r[6], r[3]})
      `CHK(g, {r[24], r[6], r[3]})
      a = 3'($urandom());
      @(posedge clk);
      acc <= a;
      @(posedge clk);
      acc <= 0;
      #1 `CHK(flt, a & ~en)
    end
    bus(1, 12'h110, 32'h0100_0008);
    @(posedge clk) pm <= PCG_SLEEP;
    repeat (2) @(posedge clk);
    #1 `CHK(en, {r[24], r[6], r[3]})
    bus(1, 12'h130, 1);
    repeat (2) @(posedge clk);
    #1 `CHK(en, 3'h5)
    @(posedge clk) pm <= PCG_DEEP;
    repeat (2) @(posedge clk);
    #1 `CHK(en, 3'h2)
    report_and_stop();
  end
endmodule
`default_nettype wire
